/* hdl/tcsas_pkg.sv */
// constants and types for the type-c source attach sequencer
`default_nettype none
package tcsas_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam logic [31:0] CLK_KHZ         = 32'h0001_86A0; // 100 MHz
  localparam logic [31:0] T_DEBOUNCE_MS   = 32'h0000_00B9; // 185 ms
  localparam logic [31:0] T_FAULT_HR_MS   = 32'h0000_0258; // 600 ms
  localparam logic [31:0] T_NO_RESP_MS    = 32'h0000_12C0; // 4.8 s
  localparam logic [31:0] DEBOUNCE_CYC    = T_DEBOUNCE_MS * CLK_KHZ;
  localparam logic [31:0] FAULT_HR_CYC    = T_FAULT_HR_MS * CLK_KHZ;
  localparam logic [31:0] NO_RESP_CYC     = T_NO_RESP_MS * CLK_KHZ;

  // ------------------------------------------------------------
  // synchronised pin inputs, bit positions
  // ------------------------------------------------------------
  localparam int IN_CC1_RANGE  = 0;
  localparam int IN_CC2_RANGE  = 1;
  localparam int IN_CC1_ABOVE  = 2;
  localparam int IN_CC2_ABOVE  = 3;
  localparam int IN_CC1_DETACH = 4;
  localparam int IN_CC2_DETACH = 5;
  localparam int IN_VBUS_LOW   = 6;
  localparam int IN_VBUS_OVP   = 7;
  localparam int IN_OCP        = 8;
  localparam int IN_THERMAL    = 9;
  localparam int IN_GATE_OVR_N = 10;
  localparam int IN_SUPPLY     = 11;
  localparam int IN_WAKE       = 12;
  localparam int NUM_IN        = 13;

  localparam logic [NUM_IN-1:0] SYNC_RESET = 13'h0000;

  // ------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    TCSAS_UNATT    = 3'b000,
    TCSAS_DEBOUNCE = 3'b001,
    TCSAS_SLP_DEB  = 3'b010,
    TCSAS_SLEEP    = 3'b011,
    TCSAS_ATTACHED = 3'b100
  } tcsas_state_t;

endpackage
`default_nettype wire

/* hdl/tcsas_tmr_if.sv */
// load/expire link between sequencer and its interval timer
`default_nettype none
interface tcsas_tmr_if;
  logic        load;
  logic [31:0] value;
  logic        expire;

  modport ctrl (output load, output value, input expire);
  modport tmr  (input load, input value, output expire);
endinterface
`default_nettype wire

/* hdl/tcsas_timer.sv */
// down-counting interval timer with one-cycle expiry pulse
`default_nettype none
module tcsas_timer
  import tcsas_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  // control link
  tcsas_tmr_if.tmr  tmr
);

  logic [31:0] count;
  logic [31:0] next_count;
  logic        fire;
  logic        next_fire;

  // ------------------------------------------------------------
  // count
  // ------------------------------------------------------------
  always_comb
  begin
    next_count = count;
    next_fire  = 1'b0;
    if (tmr.load)
    begin
      next_count = tmr.value;
    end
    else if (count != 32'h0000_0000)
    begin
      next_count = count - 32'h0000_0001;
      next_fire  = (count == 32'h0000_0001);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      count <= 32'h0000_0000;
      fire  <= 1'b0;
    end
    else
    begin
      count <= next_count;
      fire  <= next_fire;
    end
  end

  // straight from the flop: no combinational path back from load
  assign tmr.expire = fire;

endmodule // tcsas_timer
`default_nettype wire

/* hdl/tcsas_seq.sv */
// type-c source attach sequencer: detect, power, protect, retry
//
// Function
// [RL1] default pull-up while nothing is attached; the code drops it in TCSAS_SLEEP
// [RL2] attach needs one cc in range, debounced
// [RL3] detect orientation, monitor that cc pin
// [RL4] vbus on, vconn other pin, high pull-up
// [RL5] pd-capable sink gets medium pull-up
// [RL6] detach on monitored cc removes vbus
// [RL7] both cc above low: enter sleep
// [RL8] vconn enabled within 2 ms of attach
// [RL9] gate driver full within 2 ms of attach
// [RL10] logic supply high within 5 ms
// [RL11] supply fault: hard reset after 600 ms
// [RL12] silent sink: hard reset every 4.8 s
// [RL13] gate override low kills gate fast
// [RL14] vbus overvoltage kills gate within 30 us
// [RL15] overcurrent starts gate turn-off within 30 us
// [RL16] thermal limit stops discharge within 10 us
// [RL17] source caps data-capable bit always one
// [RL18] start at 5 V, higher after negotiation
// [RL19] source role only, never sink
// [RL20] 185 ms debounce, then attach indicator low
// [RL21] one clock times all; reset unattached
`default_nettype none
module tcsas_seq
  import tcsas_pkg::*;
#(
  parameter logic [31:0] DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter logic [31:0] FAULT_HR_CYCLES = FAULT_HR_CYC,
  parameter logic [31:0] NO_RESP_CYCLES  = NO_RESP_CYC
)
(
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  // cc comparators, per pin
  input  wire logic cc1_in_range_i,
  input  wire logic cc2_in_range_i,
  input  wire logic cc1_above_low_i,
  input  wire logic cc2_above_low_i,
  input  wire logic cc1_detach_i,
  input  wire logic cc2_detach_i,
  input  wire logic wake_i,
  // vbus, supply and protection sensing
  input  wire logic vbus_below_fast_i,
  input  wire logic vbus_ovp_i,
  input  wire logic current_sense_trip_i,
  input  wire logic thermal_limit_one_i,
  input  wire logic gate_override_n_i,
  input  wire logic supply_sense_input_i,
  // pd engine, same clock
  input  wire logic pd_capable_i,
  input  wire logic pd_activity_i,
  input  wire logic contract_high_v_i,
  input  wire logic discharge_req_i,
  // cc current sources
  output logic      default_pullup_current_o,
  output logic      high_pullup_current_o,
  output logic      medium_pullup_current_o,
  output logic      sleep_mode_o,
  output logic      cc_orient_o,
  // power path
  output logic      vconn_cc1_en_o,
  output logic      vconn_cc2_en_o,
  output logic      vbus_nfet_gate_drive_o,
  output logic      vbus_high_v_en_o,
  output logic      discharge_en_o,
  output logic      switched_logic_supply_o,
  // status and pd
  output logic      attach_indicator_n_o,
  output logic      hard_reset_tx_o,
  output logic      caps_data_capable_o,
  output logic      source_role_o
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [NUM_IN-1:0] pins;
  logic [NUM_IN-1:0] s1;
  logic [NUM_IN-1:0] s2;
  logic [NUM_IN-1:0] s3;
  logic [NUM_IN-1:0] filt;
  logic [NUM_IN-1:0] next_filt;

  assign pins[IN_CC1_RANGE]  = cc1_in_range_i;
  assign pins[IN_CC2_RANGE]  = cc2_in_range_i;
  assign pins[IN_CC1_ABOVE]  = cc1_above_low_i;
  assign pins[IN_CC2_ABOVE]  = cc2_above_low_i;
  assign pins[IN_CC1_DETACH] = cc1_detach_i;
  assign pins[IN_CC2_DETACH] = cc2_detach_i;
  assign pins[IN_VBUS_LOW]   = vbus_below_fast_i;
  assign pins[IN_VBUS_OVP]   = vbus_ovp_i;
  assign pins[IN_OCP]        = current_sense_trip_i;
  assign pins[IN_THERMAL]    = thermal_limit_one_i;
  assign pins[IN_GATE_OVR_N] = gate_override_n_i;
  assign pins[IN_SUPPLY]     = supply_sense_input_i;
  assign pins[IN_WAKE]       = wake_i;

  // s1 feeds only s2; a change counts once s2 and s3 agree
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++)
    begin : g_sync
      always_comb
      begin
        next_filt[gi] = (s2[gi] == s3[gi]) ? s3[gi] : filt[gi];
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s1   <= SYNC_RESET;
      s2   <= SYNC_RESET;
      s3   <= SYNC_RESET;
      filt <= SYNC_RESET;
    end
    else
    begin
      s1   <= pins;
      s2   <= s1;
      s3   <= s2;
      filt <= next_filt;
    end
  end

  // ------------------------------------------------------------
  // interval timer
  // ------------------------------------------------------------
  tcsas_tmr_if tmr_link ();

  tcsas_timer u_timer (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .tmr       (tmr_link.tmr)
  );

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  tcsas_state_t state;
  tcsas_state_t next_state;
  logic         orient;
  logic         next_orient;
  logic         fast_flt;
  logic         next_fast_flt;
  logic         next_hr;
  logic         one_in_range;
  logic         both_above;
  logic         mon_detach;
  logic         supply_flt;
  logic         fast_cond;
  logic [31:0]  retry_load;

  always_comb
  begin
    one_in_range = filt[IN_CC1_RANGE] ^ filt[IN_CC2_RANGE];   // RL2
    both_above   = filt[IN_CC1_ABOVE] & filt[IN_CC2_ABOVE];   // RL7
    mon_detach   = orient ? filt[IN_CC2_DETACH]
                          : filt[IN_CC1_DETACH];              // RL3
    supply_flt   = ~filt[IN_GATE_OVR_N] | ~filt[IN_SUPPLY];   // RL11
    fast_cond    = filt[IN_VBUS_OVP] | filt[IN_OCP]
                 | ~filt[IN_GATE_OVR_N];
    retry_load   = supply_flt ? FAULT_HR_CYCLES
                              : NO_RESP_CYCLES;
    next_state     = state;
    next_orient    = orient;
    next_fast_flt  = fast_flt;
    next_hr        = 1'b0;
    tmr_link.load  = 1'b0;
    tmr_link.value = DEBOUNCE_CYCLES;
    case (state)
      TCSAS_UNATT:
      begin
        if (one_in_range && filt[IN_VBUS_LOW])
        begin
          next_state    = TCSAS_DEBOUNCE;                     // RL2
          tmr_link.load = 1'b1;
        end
        else if (both_above)
        begin
          next_state    = TCSAS_SLP_DEB;                      // RL7
          tmr_link.load = 1'b1;
        end
      end
      TCSAS_DEBOUNCE:
      begin
        if (!(one_in_range && filt[IN_VBUS_LOW]))
        begin
          next_state = TCSAS_UNATT;                           // RL2
        end
        else if (tmr_link.expire)
        begin
          next_state     = TCSAS_ATTACHED;                    // RL20
          next_orient    = filt[IN_CC2_RANGE];                // RL3
          next_fast_flt  = 1'b0;
          tmr_link.load  = 1'b1;
          tmr_link.value = retry_load;                        // RL11
        end
      end
      TCSAS_SLP_DEB:
      begin
        if (!both_above)
        begin
          next_state = TCSAS_UNATT;
        end
        else if (tmr_link.expire)
        begin
          next_state = TCSAS_SLEEP;                           // RL7
        end
      end
      TCSAS_SLEEP:
      begin
        if (filt[IN_WAKE])
        begin
          next_state = TCSAS_UNATT;                           // RL7
        end
      end
      TCSAS_ATTACHED:
      begin
        if (mon_detach)
        begin
          next_state = TCSAS_UNATT;                           // RL6
        end
        else
        begin
          if (tmr_link.expire)
          begin
            next_hr        = 1'b1;                            // RL12
            tmr_link.load  = 1'b1;
            tmr_link.value = retry_load;                      // RL11
            next_fast_flt  = 1'b0;
          end
          else if (pd_activity_i)
          begin
            tmr_link.load  = 1'b1;                            // RL12
            tmr_link.value = retry_load;
          end
          // a new trip in the retry cycle still latches
          if (fast_cond)
          begin
            next_fast_flt = 1'b1;                             // RL14
          end
        end
      end
      default:
      begin
        next_state = TCSAS_UNATT;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state    <= TCSAS_UNATT;                                // RL21
      orient   <= 1'b0;
      fast_flt <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      orient   <= next_orient;
      fast_flt <= next_fast_flt;
    end
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  logic att;
  logic next_gate;
  logic next_dflt_pu;

  always_comb
  begin
    att          = (next_state == TCSAS_ATTACHED);
    next_dflt_pu = (next_state == TCSAS_UNATT)
                 | (next_state == TCSAS_DEBOUNCE)
                 | (next_state == TCSAS_SLP_DEB);             // RL1
    // trip inputs gate directly so the cut lands a cycle early
    next_gate    = att & filt[IN_GATE_OVR_N]                  // RL13
                 & filt[IN_SUPPLY]                            // RL11
                 & ~filt[IN_VBUS_OVP]                         // RL14
                 & ~filt[IN_OCP]                              // RL15
                 & ~next_fast_flt;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      default_pullup_current_o <= 1'b1;
      high_pullup_current_o    <= 1'b0;
      medium_pullup_current_o  <= 1'b0;
      sleep_mode_o             <= 1'b0;
      cc_orient_o              <= 1'b0;
      vconn_cc1_en_o           <= 1'b0;
      vconn_cc2_en_o           <= 1'b0;
      vbus_nfet_gate_drive_o   <= 1'b0;
      vbus_high_v_en_o         <= 1'b0;
      discharge_en_o           <= 1'b0;
      switched_logic_supply_o  <= 1'b0;
      attach_indicator_n_o     <= 1'b1;
      hard_reset_tx_o          <= 1'b0;
      caps_data_capable_o      <= 1'b1;
      source_role_o            <= 1'b1;
    end
    else
    begin
      default_pullup_current_o <= next_dflt_pu;               // RL1
      high_pullup_current_o    <= att & ~pd_capable_i;        // RL4
      medium_pullup_current_o  <= att & pd_capable_i;         // RL5
      sleep_mode_o             <= (next_state == TCSAS_SLEEP); // RL7
      cc_orient_o              <= next_orient;                // RL3
      vconn_cc1_en_o           <= att & next_orient;          // RL8
      vconn_cc2_en_o           <= att & ~next_orient;         // RL4
      vbus_nfet_gate_drive_o   <= next_gate;                  // RL9
      // stays at 5 V until a contract asks for more
      vbus_high_v_en_o         <= next_gate & contract_high_v_i; // RL18
      discharge_en_o           <= discharge_req_i
                                & ~filt[IN_THERMAL];          // RL16
      switched_logic_supply_o  <= att;                        // RL10
      attach_indicator_n_o     <= ~att;                       // RL20
      hard_reset_tx_o          <= next_hr;                    // RL12
      caps_data_capable_o      <= 1'b1;                       // RL17
      source_role_o            <= 1'b1;                       // RL19
    end
  end

endmodule // tcsas_seq
`default_nettype wire

/* bench/tcsas_seq_properties.sv */
// port assertions for the attach sequencer
`default_nettype none
module tcsas_seq_properties
  import tcsas_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // sensed inputs
  input wire logic gate_override_n_i,
  input wire logic vbus_ovp_i,
  input wire logic current_sense_trip_i,
  input wire logic thermal_limit_one_i,
  input wire logic pd_capable_i,
  // outputs watched
  input wire logic default_pullup_current_o,
  input wire logic high_pullup_current_o,
  input wire logic medium_pullup_current_o,
  input wire logic sleep_mode_o,
  input wire logic cc_orient_o,
  input wire logic vconn_cc1_en_o,
  input wire logic vconn_cc2_en_o,
  input wire logic vbus_nfet_gate_drive_o,
  input wire logic vbus_high_v_en_o,
  input wire logic discharge_en_o,
  input wire logic switched_logic_supply_o,
  input wire logic attach_indicator_n_o,
  input wire logic hard_reset_tx_o,
  input wire logic caps_data_capable_o,
  input wire logic source_role_o
);
  // ----------------
  // port rules
  // ----------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);

  a_unatt_rp: assert property (
    attach_indicator_n_o && !sleep_mode_o |-> default_pullup_current_o
      && !high_pullup_current_o && !medium_pullup_current_o)
    else $error("pull-up wrong while unattached");
  a_rp_select: assert property (
    !attach_indicator_n_o && !$past(attach_indicator_n_o) |->
      medium_pullup_current_o == $past(pd_capable_i)
      && high_pullup_current_o != $past(pd_capable_i))
    else $error("pull-up level does not follow pd capability");
  a_vconn_side: assert property (
    !attach_indicator_n_o |-> vconn_cc1_en_o == cc_orient_o
      && vconn_cc2_en_o != cc_orient_o)
    else $error("vconn not on the unused cc pin");
  a_attach_on: assert property (
    $fell(attach_indicator_n_o) |-> switched_logic_supply_o
      && !default_pullup_current_o && !vbus_high_v_en_o)
    else $error("attach edge outputs wrong");
  a_override_off: assert property (
    $fell(gate_override_n_i) |-> ##5 !vbus_nfet_gate_drive_o)
    else $error("gate still on after override");
  a_ovp_off: assert property (
    $rose(vbus_ovp_i) |-> ##5 !vbus_nfet_gate_drive_o)
    else $error("gate still on after overvoltage");
  a_ocp_off: assert property (
    $rose(current_sense_trip_i) |-> ##5 !vbus_nfet_gate_drive_o)
    else $error("gate still on after overcurrent");
  a_thermal_dsch: assert property (
    thermal_limit_one_i [*6] |-> !discharge_en_o)
    else $error("discharge on above thermal limit");
  a_const_bits: assert property (
    caps_data_capable_o && source_role_o)
    else $error("data-capable or source bit low");
  a_hr_pulse: assert property (
    hard_reset_tx_o |-> !attach_indicator_n_o ##1 !hard_reset_tx_o)
    else $error("hard reset pulse malformed");

  c_attach: cover property ($fell(attach_indicator_n_o));
  c_sleep: cover property ($rose(sleep_mode_o));
  c_hard_reset: cover property (hard_reset_tx_o);
endmodule // tcsas_seq_properties
`default_nettype wire

/* bench/tcsas_sink_model.sv */
// behavioural sink on cc and vbus
`default_nettype none
module tcsas_sink_model
  import tcsas_pkg::*;
(
  // clock
  input  wire logic       ref_clk_i,
  // scenario control
  input  wire logic       plug_i,
  input  wire logic       flip_i,
  input  wire logic [7:0] talk_gap_i,
  input  wire logic       vbus_on_i,
  // comparator view of the sink
  output logic            cc1_in_range_o,
  output logic            cc2_in_range_o,
  output logic            cc1_above_low_o,
  output logic            cc2_above_low_o,
  output logic            cc1_detach_o,
  output logic            cc2_detach_o,
  output logic            wake_o,
  output logic            vbus_below_fast_o,
  output logic            pd_activity_o
);
  logic [7:0] cnt;

  // open pin floats past every threshold; pulled pin sits in range
  assign cc1_in_range_o    = plug_i && !flip_i;
  assign cc2_in_range_o    = plug_i && flip_i;
  assign cc1_above_low_o   = 1'b1;
  assign cc2_above_low_o   = 1'b1;
  assign cc1_detach_o      = !cc1_in_range_o;
  assign cc2_detach_o      = !cc2_in_range_o;
  assign wake_o            = plug_i;
  assign vbus_below_fast_o = !vbus_on_i;

  // gap of zero: a silent sink
  initial cnt = 8'h00;
  initial pd_activity_o = 1'b0;
  always @(negedge ref_clk_i)
  begin
    cnt <= (talk_gap_i == 8'h00 || cnt == talk_gap_i) ? 8'h00 : cnt + 8'h01;
    pd_activity_o <= talk_gap_i != 8'h00 && cnt == talk_gap_i;
  end
endmodule // tcsas_sink_model
`default_nettype wire

/* bench/test_tcsas_seq.sv */
// self-checking bench for the attach sequencer
`default_nettype none
module test_tcsas_seq
  import tcsas_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // short counts keep the run brief
  localparam logic [31:0] DEB = 32'h0000_0032;
  localparam logic [31:0] FHR = 32'h0000_0050;
  localparam logic [31:0] NRS = 32'h0000_0078;
  logic ref_clk_i = 1'b0, rstn_i = 1'b0, plug = 1'b0, flip = 1'b0;
  logic stuck = 1'b0, vbus_ovp_i = 1'b0, current_sense_trip_i = 1'b0;
  logic thermal_limit_one_i = 1'b0, gate_override_n_i = 1'b1;
  logic supply_sense_input_i = 1'b1, pd_capable_i = 1'b0;
  logic contract_high_v_i = 1'b0, discharge_req_i = 1'b0;
  logic [7:0] gap = 8'h00;
  logic cc1_in_range_i, cc2_in_range_i, cc1_above_low_i, cc2_above_low_i;
  logic cc1_detach_i, cc2_detach_i, wake_i, vbus_below_fast_i;
  logic pd_activity_i, default_pullup_current_o, high_pullup_current_o;
  logic medium_pullup_current_o, sleep_mode_o, cc_orient_o, vconn_cc1_en_o;
  logic vconn_cc2_en_o, vbus_nfet_gate_drive_o, vbus_high_v_en_o;
  logic discharge_en_o, switched_logic_supply_o, attach_indicator_n_o;
  logic hard_reset_tx_o, caps_data_capable_o, source_role_o;
  int   err_count = 0;
  int   comparisons = 0;
  int   n;

  always #5 ref_clk_i = !ref_clk_i;

  tcsas_seq #(.DEBOUNCE_CYCLES(DEB), .FAULT_HR_CYCLES(FHR),
    .NO_RESP_CYCLES(NRS)) tcsas_seq_i (.ref_clk_i, .rstn_i,
    .cc1_in_range_i, .cc2_in_range_i, .cc1_above_low_i, .cc2_above_low_i,
    .cc1_detach_i, .cc2_detach_i, .wake_i, .vbus_below_fast_i, .vbus_ovp_i,
    .current_sense_trip_i, .thermal_limit_one_i, .gate_override_n_i,
    .supply_sense_input_i, .pd_capable_i, .pd_activity_i,
    .contract_high_v_i, .discharge_req_i, .default_pullup_current_o,
    .high_pullup_current_o, .medium_pullup_current_o, .sleep_mode_o,
    .cc_orient_o, .vconn_cc1_en_o, .vconn_cc2_en_o, .vbus_nfet_gate_drive_o,
    .vbus_high_v_en_o, .discharge_en_o, .switched_logic_supply_o,
    .attach_indicator_n_o, .hard_reset_tx_o, .caps_data_capable_o,
    .source_role_o);

  tcsas_sink_model tcsas_sink_model_i (.ref_clk_i, .plug_i(plug),
    .flip_i(flip), .talk_gap_i(gap),
    .vbus_on_i(vbus_nfet_gate_drive_o || stuck),
    .cc1_in_range_o(cc1_in_range_i), .cc2_in_range_o(cc2_in_range_i),
    .cc1_above_low_o(cc1_above_low_i), .cc2_above_low_o(cc2_above_low_i),
    .cc1_detach_o(cc1_detach_i), .cc2_detach_o(cc2_detach_i),
    .wake_o(wake_i), .vbus_below_fast_o(vbus_below_fast_i),
    .pd_activity_o(pd_activity_i));

  // ----------------
  // helpers
  // ----------------
  task automatic chk(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(negedge ref_clk_i);
  endtask

  task automatic attach(output int c);
    plug = 1'b1;
    c = 0;
    while (attach_indicator_n_o !== 1'b0 && c < 400)
    begin
      tick(1);
      c++;
    end
  endtask

  // skips a pulse still showing, so a search never sees it twice
  task automatic wait_hr(output int c);
    c = 0;
    tick(1);
    while (hard_reset_tx_o !== 1'b1 && c < 400)
    begin
      tick(1);
      c++;
    end
  endtask

  task automatic detach();
    plug = 1'b0;
    tick(8);
    chk("detach", {attach_indicator_n_o, vbus_nfet_gate_drive_o,
      default_pullup_current_o}, 3'b101);
  endtask

  task automatic complete_run();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------
  // scenarios
  // ----------------
  task automatic t_reset();
    chk("reset outputs", {default_pullup_current_o, attach_indicator_n_o,
      vbus_nfet_gate_drive_o, vconn_cc1_en_o, vconn_cc2_en_o,
      caps_data_capable_o, source_role_o, hard_reset_tx_o}, 8'hC6);
    tick(DEB + 20);
    chk("sleep with no sink", sleep_mode_o, 1'b1);
    $display("test reset done");
  endtask

  task automatic t_attach(input logic f, input logic pd);
    flip = f;
    pd_capable_i = pd;
    attach(n);
    chk("debounce length", n >= DEB && n < 400, 1'b1);
    chk("orientation", cc_orient_o, f);
    chk("vconn pins", {vconn_cc1_en_o, vconn_cc2_en_o}, {f, !f});
    chk("rp level", {high_pullup_current_o, medium_pullup_current_o,
      default_pullup_current_o}, {!pd, pd, 1'b0});
    chk("gate on", vbus_nfet_gate_drive_o, 1'b1);
    chk("logic supply", switched_logic_supply_o, 1'b1);
    chk("five volts first", vbus_high_v_en_o, 1'b0);
    pd_capable_i = !pd;
    contract_high_v_i = 1'b1;
    tick(2);
    chk("rp follows pd", medium_pullup_current_o, !pd);
    chk("higher after contract", vbus_high_v_en_o, 1'b1);
    contract_high_v_i = 1'b0;
    detach();
    $display("test attach done");
  endtask

  task automatic t_vbus_block();
    stuck = 1'b1;
    plug = 1'b1;
    tick(DEB + 60);
    chk("no attach with vbus up", attach_indicator_n_o, 1'b1);
    stuck = 1'b0;
    attach(n);
    chk("attach after vbus low", n < 400, 1'b1);
    detach();
    $display("test vbus block done");
  endtask

  task automatic t_retry();
    attach(n);
    wait_hr(n);
    chk("first retry", n >= NRS - 2 && n <= NRS + 4, 1'b1);
    wait_hr(n);
    chk("next retry", n >= NRS - 2 && n <= NRS + 2, 1'b1);
    gap = 8'h28;
    wait_hr(n);
    chk("talking sink no retry", n, 400);
    gap = 8'h00;
    detach();
    $display("test retry done");
  endtask

  task automatic t_fault();
    supply_sense_input_i = 1'b0;
    attach(n);
    chk("no gate on fault", vbus_nfet_gate_drive_o, 1'b0);
    wait_hr(n);
    chk("fault hard reset", n >= FHR - 2 && n <= FHR + 4, 1'b1);
    supply_sense_input_i = 1'b1;
    detach();
    $display("test fault done");
  endtask

  task automatic t_trips();
    for (int k = 0; k < 3; k++)
    begin
      attach(n);
      gate_override_n_i = k != 0;
      vbus_ovp_i = k == 1;
      current_sense_trip_i = k == 2;
      tick(6);
      chk("gate off on trip", vbus_nfet_gate_drive_o, 1'b0);
      {gate_override_n_i, vbus_ovp_i, current_sense_trip_i} = 3'b100;
      detach();
    end
    discharge_req_i = 1'b1;
    tick(2);
    chk("discharge on cool", discharge_en_o, 1'b1);
    thermal_limit_one_i = 1'b1;
    tick(8);
    chk("discharge stops hot", discharge_en_o, 1'b0);
    {discharge_req_i, thermal_limit_one_i} = 2'b00;
    $display("test trips done");
  endtask

  initial
  begin
    tick(3);
    rstn_i = 1'b1;
    tick(1);
    t_reset();
    t_attach(1'b0, 1'b0);
    t_attach(1'b1, 1'b1);
    t_vbus_block();
    t_retry();
    t_fault();
    t_trips();
    complete_run();
  end

  // watchdog well past the expected run of under two thousand cycles
  initial
  begin
    tick(20000);
    err_count++;
    complete_run();
  end
endmodule // test_tcsas_seq

bind tcsas_seq tcsas_seq_properties tcsas_seq_properties_i (.ref_clk_i,
  .rstn_i, .gate_override_n_i, .vbus_ovp_i, .current_sense_trip_i,
  .thermal_limit_one_i, .pd_capable_i, .default_pullup_current_o,
  .high_pullup_current_o, .medium_pullup_current_o, .sleep_mode_o,
  .cc_orient_o, .vconn_cc1_en_o, .vconn_cc2_en_o, .vbus_nfet_gate_drive_o,
  .vbus_high_v_en_o, .discharge_en_o, .switched_logic_supply_o,
  .attach_indicator_n_o, .hard_reset_tx_o, .caps_data_capable_o,
  .source_role_o);
`default_nettype wire
